// File: lnk_defs.svh
// Register offsets, field positions and reset values for the node-layer port.
// Assumes byte addressing on an 8-bit Avalon-MM address, one word per register.
`ifndef LNK_DEFS_SVH
`define LNK_DEFS_SVH
`define LNK_ADDR_W 8
`define LNK_OFS_CTRL 8'h00
`define LNK_OFS_STATUS 8'h04
`define LNK_OFS_IRQ_STAT 8'h08
`define LNK_OFS_IRQ_MASK 8'h0c
`define LNK_OFS_VECTOR 8'h10
`define LNK_OFS_TX_ADDR_LO 8'h14
`define LNK_OFS_TX_ADDR_HI 8'h18
`define LNK_OFS_TX_DATA_LO 8'h1c
`define LNK_OFS_TX_DATA_HI 8'h20
`define LNK_OFS_TX_DONE 8'h24
`define LNK_OFS_IRQ_WORD 8'h28
`define LNK_OFS_IRQ_DONE 8'h2c
`define LNK_OFS_RX_ADDR_LO 8'h30
`define LNK_OFS_RX_ADDR_HI 8'h34
`define LNK_OFS_RX_DATA_LO 8'h38
`define LNK_OFS_RX_CMD 8'h3c
`define LNK_OFS_RX_DATA_HI 8'h40
`define LNK_CTRL_WIDE_BIT 0
`define LNK_CTRL_BIG_BIT 1
`define LNK_CTRL_RST 2'h0
`define LNK_EV_TX 0
`define LNK_EV_IRQ 1
`define LNK_EV_RX 2
`define LNK_EV_W 3
`define LNK_RX_CMD_DW_BIT 2
`define LNK_IRQ_NMI_BIT 16
`define LNK_BEATS 16
`endif

// File: lnk_pkg.sv
// Types shared by the node-layer port: receive phase and the whole state record.
// Assumes lnk_defs.svh is on the include path.
`include "lnk_defs.svh"
package lnk_pkg;
	typedef enum logic [1:0] {RX_EMPTY, RX_LOADED, RX_STROBE} lnk_rx_phase_t;
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic wide;
		logic big_end;
		logic [15:0] vector;
		logic vec_set;
		logic tx_busy;
		logic [39:0] tx_addr;
		logic [3:0] tx_write_count;
		logic [3:0] wr_ptr;
		logic [3:0] rd_ptr;
		logic [`LNK_BEATS-1:0][63:0] beats;
		logic irq_busy;
		logic [15:0] irq_word;
		logic irq_nmi;
		logic [`LNK_EV_W-1:0] ev;
		logic [`LNK_EV_W-1:0] mask;
		lnk_rx_phase_t rx_phase;
		logic [39:2] rx_addr;
		logic [63:0] rx_data;
		logic rx_doubleword_flag;
		logic [39:2] rx_addr_q;
		logic [63:0] rx_data_q;
		logic [7:0] rx_mask_q;
		logic rx_doubleword_flag_q;
	} lnk_state_t;
endpackage

// File: lnk_lane_order.sv
// Byte-lane orderer for the 64-bit receive data path.
// Assumes little-endian register data; purely combinational.
`timescale 1ns/1ns
module lnk_lane_order #(
	parameter int LANE_W = 32
) (
	input wire logic [2*LANE_W-1:0] data_i,
	input wire logic big_end_i,
	input wire logic wide_i,
	output logic [2*LANE_W-1:0] data_o
);
	localparam int NB = LANE_W / 8;
	logic [LANE_W-1:0] lo_sw;
	logic [LANE_W-1:0] hi_sw;
	// Byte reversal inside each lane
	for (genvar b = 0; b < NB; b++) begin : g_byte
		assign lo_sw[8*b +: 8] = data_i[8*(NB-1-b) +: 8];
		assign hi_sw[8*b +: 8] = data_i[LANE_W + 8*(NB-1-b) +: 8];
	end
	// Big-endian wide mode also swaps the lanes; narrow mode clears the upper lane
	always_comb begin
		if (!big_end_i) begin
			data_o = {data_i[2*LANE_W-1:LANE_W], data_i[LANE_W-1:0]};
		end else if (wide_i) begin
			data_o = {lo_sw, hi_sw};
		end else begin
			data_o = {hi_sw, lo_sw};
		end
		if (!wide_i) begin
			data_o[2*LANE_W-1:LANE_W] = '0;
		end
	end
endmodule

// File: lnk_node_port.sv
// Node-layer side of the device-layer port: transmit write capture, interrupt
// vector capture and receive command delivery, with an Avalon-MM register slave.
// Assumes all device-layer inputs are synchronous to ref_clk_i.
// What this block does
// R1: Device layer drives write strobe low to start a posted write.
// R2: Device layer drives beat strobe low for each further data beat.
// R3: Node layer shows idle while able to take a new write request.
// R4: Device layer gives a 16-bit request word; vector comes from registers.
// R5: Non-maskable select low makes the node build an NMI packet.
// R6: Device layer clears its request flop when none-pending is asserted.
// R7: Lower four receive mask bits are all equal, high meaning valid.
// R8: Wide mode also drives upper four mask bits, same convention.
// R9: Upper receive data lane delivered only in wide mode, endian ordered.
// R10: Lower receive data bits ordered by the endianness setting.
// R11: Device layer raises next-command request; lowers it when busy.
// R12: Node pulses receive write strobe low for a valid write command.
// R13: Size flag is bit 2 of the write command, 1 doubleword.
// R14: None-pending stays high while the interrupt framer is idle.
// R15: Device layer asserts vector load to have the vector captured.
// R16: Device layer supplies a four-bit count with each write request.
// R17: Device layer starts only when idle, holds fields until strobe taken.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`include "lnk_defs.svh"
module lnk_node_port #(
	parameter int BEATS = `LNK_BEATS
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [`LNK_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	input wire logic [39:0] tx_addr_i,
	input wire logic [63:0] tx_data_i,
	input wire logic [3:0] tx_write_count_i,
	input wire logic tx_write_strobe_n_i,
	input wire logic tx_beat_strobe_n_i,
	output logic tx_idle_o,
	input wire logic [15:0] irq_request_word_i,
	input wire logic irq_vector_load_i,
	input wire logic irq_nmi_select_n_i,
	output logic irq_none_pending_o,
	output logic [39:2] rx_addr_o,
	output logic [63:0] rx_data_o,
	output logic [7:0] rx_byte_mask_o,
	input wire logic rx_next_command_req_i,
	output logic rx_write_strobe_n_o,
	output logic rx_doubleword_flag_o
);
	import lnk_pkg::*;

	lnk_state_t s;
	lnk_state_t s_next;
	logic [63:0] rx_ordered;

	// Merge byte lanes of a bus write into an old word
	function automatic logic [31:0] be_merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Receive lanes reordered before capture so outputs come straight from flops
	lnk_lane_order #(
		.LANE_W(32)
	) u_order (
		.data_i(s.rx_data),
		.big_end_i(s.big_end),
		.wide_i(s.wide),
		.data_o(rx_ordered)
	);

	logic req;
	logic wr_fire;
	logic rd_fire;
	assign req = avs_read_i | avs_write_i;
	assign wr_fire = avs_write_i & s.ack;
	assign rd_fire = avs_read_i & s.ack;

	// Handshake and data outputs
	assign avs_waitrequest_o = req & ~s.ack;
	assign avs_readdata_o = s.rdata;
	assign irq_o = |(s.ev & s.mask);
	assign tx_idle_o = ~s.tx_busy; // [R3]
	assign irq_none_pending_o = ~s.irq_busy; // [R14]
	assign rx_write_strobe_n_o = (s.rx_phase != RX_STROBE); // [R12]
	assign rx_addr_o = s.rx_addr_q;
	assign rx_data_o = s.rx_data_q;
	assign rx_byte_mask_o = s.rx_mask_q;
	assign rx_doubleword_flag_o = s.rx_doubleword_flag_q;

	// Whole next state in one place
	always_comb begin
		logic [`LNK_EV_W-1:0] ev_set;
		logic [`LNK_EV_W-1:0] ev_clr;
		logic [63:0] beat;
		ev_set = '0;
		ev_clr = '0;
		beat = s.beats[s.rd_ptr];
		s_next = s;
		// Bus slave: one wait cycle, then the access completes
		s_next.ack = req & ~s.ack;
		if (req && !s.ack) begin
			s_next.rdata = 32'h0;
			case (avs_address_i)
				`LNK_OFS_CTRL: s_next.rdata = {30'h0, s.big_end, s.wide};
				`LNK_OFS_STATUS: s_next.rdata = {29'h0, s.rx_phase != RX_EMPTY, s.irq_busy,
					s.tx_busy};
				`LNK_OFS_IRQ_STAT: s_next.rdata = {29'h0, s.ev};
				`LNK_OFS_IRQ_MASK: s_next.rdata = {29'h0, s.mask};
				`LNK_OFS_VECTOR: s_next.rdata = {16'h0, s.vector};
				`LNK_OFS_TX_ADDR_LO: s_next.rdata = s.tx_addr[31:0];
				`LNK_OFS_TX_ADDR_HI: s_next.rdata = {16'h0, s.rd_ptr, s.tx_write_count, s.tx_addr[39:32]};
				`LNK_OFS_TX_DATA_LO: s_next.rdata = beat[31:0];
				`LNK_OFS_TX_DATA_HI: s_next.rdata = beat[63:32];
				`LNK_OFS_IRQ_WORD: s_next.rdata = {15'h0, s.irq_nmi, s.irq_word};
				`LNK_OFS_RX_ADDR_LO: s_next.rdata = {s.rx_addr[31:2], 2'h0};
				`LNK_OFS_RX_ADDR_HI: s_next.rdata = {24'h0, s.rx_addr[39:32]};
				`LNK_OFS_RX_DATA_LO: s_next.rdata = s.rx_data[31:0];
				`LNK_OFS_RX_DATA_HI: s_next.rdata = s.rx_data[63:32];
				`LNK_OFS_RX_CMD: s_next.rdata = {29'h0, s.rx_doubleword_flag, 2'h0};
				default: s_next.rdata = 32'h0;
			endcase
		end
		// Side effects of completed reads
		if (rd_fire) begin
			case (avs_address_i)
				`LNK_OFS_IRQ_STAT: ev_clr = s.ev;
				`LNK_OFS_TX_DATA_HI: s_next.rd_ptr = s.rd_ptr + 4'h1;
				default: ;
			endcase
		end
		// Completed writes; unmapped offsets are ignored
		if (wr_fire) begin
			case (avs_address_i)
				`LNK_OFS_CTRL: begin
					if (avs_byteenable_i[0]) begin
						s_next.wide = avs_writedata_i[`LNK_CTRL_WIDE_BIT];
						s_next.big_end = avs_writedata_i[`LNK_CTRL_BIG_BIT];
					end
				end
				`LNK_OFS_IRQ_MASK: begin
					if (avs_byteenable_i[0]) begin
						s_next.mask = avs_writedata_i[`LNK_EV_W-1:0];
					end
				end
				`LNK_OFS_VECTOR: begin
					s_next.vector = 16'(be_merge({16'h0, s.vector}, avs_writedata_i,
						avs_byteenable_i));
					s_next.vec_set = 1'b1;
				end
				`LNK_OFS_TX_DONE: begin
					s_next.tx_busy = 1'b0;
					s_next.rd_ptr = 4'h0;
				end
				`LNK_OFS_IRQ_DONE: s_next.irq_busy = 1'b0;
				`LNK_OFS_RX_ADDR_LO: s_next.rx_addr[31:2] = 30'(be_merge({s.rx_addr[31:2], 2'h0},
					avs_writedata_i, avs_byteenable_i) >> 2);
				`LNK_OFS_RX_ADDR_HI: begin
					if (avs_byteenable_i[0]) begin
						s_next.rx_addr[39:32] = avs_writedata_i[7:0];
					end
				end
				`LNK_OFS_RX_DATA_LO: s_next.rx_data[31:0] = be_merge(s.rx_data[31:0],
					avs_writedata_i, avs_byteenable_i);
				`LNK_OFS_RX_DATA_HI: s_next.rx_data[63:32] = be_merge(s.rx_data[63:32],
					avs_writedata_i, avs_byteenable_i);
				`LNK_OFS_RX_CMD: begin
					// Posting while a command is still loaded overwrites it
					s_next.rx_doubleword_flag = avs_writedata_i[`LNK_RX_CMD_DW_BIT]; // [R13]
					s_next.rx_phase = RX_LOADED;
				end
				default: ;
			endcase
		end
		// Transmit write capture; a start strobe while busy is ignored
		if (!s.tx_busy && !tx_write_strobe_n_i) begin
			s_next.tx_busy = 1'b1; // [R3]
			s_next.tx_addr = tx_addr_i;
			s_next.tx_write_count = tx_write_count_i;
			s_next.beats[0] = tx_data_i;
			s_next.wr_ptr = 4'h1;
			s_next.rd_ptr = 4'h0;
			ev_set[`LNK_EV_TX] = 1'b1;
		end else if (s.tx_busy && !tx_beat_strobe_n_i) begin
			// Beats past the buffer depth wrap; the count field bounds a legal burst
			s_next.beats[s.wr_ptr] = tx_data_i;
			s_next.wr_ptr = s.wr_ptr + 4'h1;
		end
		// Interrupt vector capture while the framer is idle
		if (!s.irq_busy && irq_vector_load_i) begin
			s_next.irq_busy = 1'b1; // [R14]
			s_next.irq_word = irq_request_word_i;
			// Unprogrammed vector register also forces the non-maskable type
			s_next.irq_nmi = ~irq_nmi_select_n_i | ~s.vec_set; // [R5]
			ev_set[`LNK_EV_IRQ] = 1'b1;
		end
		// Receive command delivery paced by the next-command request
		case (s.rx_phase)
			RX_EMPTY: ;
			RX_LOADED: begin
				if (rx_next_command_req_i && !wr_fire) begin
					s_next.rx_phase = RX_STROBE; // [R12]
					s_next.rx_addr_q = s.rx_addr;
					s_next.rx_data_q = rx_ordered; // [R9] [R10]
					s_next.rx_mask_q = {{4{s.wide}}, 4'hf}; // [R7] [R8]
					s_next.rx_doubleword_flag_q = s.rx_doubleword_flag; // [R13]
				end
			end
			RX_STROBE: begin
				if (!(wr_fire && avs_address_i == `LNK_OFS_RX_CMD)) begin
					s_next.rx_phase = RX_EMPTY;
				end
				s_next.rx_mask_q = 8'h00;
				ev_set[`LNK_EV_RX] = 1'b1;
			end
			default: s_next.rx_phase = RX_EMPTY;
		endcase
		// Sticky events: a new event beats a read-clear in the same cycle
		s_next.ev = (s.ev & ~ev_clr) | ev_set;
	end

	// Single state register
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.wide <= 1'(`LNK_CTRL_RST >> `LNK_CTRL_WIDE_BIT);
			s.big_end <= 1'(`LNK_CTRL_RST >> `LNK_CTRL_BIG_BIT);
			s.rx_phase <= RX_EMPTY;
		end else begin
			s <= s_next;
		end
	end

	// Byte swap helper for checking lane order
	function automatic logic [31:0] bswap(input logic [31:0] d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction

	property p_tx_idle_drop;
		@(posedge ref_clk_i) disable iff (rst_i)
		(tx_idle_o && !tx_write_strobe_n_i) |=> !tx_idle_o && s.tx_addr == $past(tx_addr_i);
	endproperty
	a_tx_idle_drop: assert property (p_tx_idle_drop) else $error("idle did not drop"); // [R3]

	property p_nmi_sel;
		@(posedge ref_clk_i) disable iff (rst_i)
		(irq_none_pending_o && irq_vector_load_i && !irq_nmi_select_n_i) |=> s.irq_nmi;
	endproperty
	a_nmi_sel: assert property (p_nmi_sel) else $error("nmi select not honoured"); // [R5]

	property p_mask_lo;
		@(posedge ref_clk_i) disable iff (rst_i)
		!rx_write_strobe_n_o |-> rx_byte_mask_o[3:0] == 4'hf;
	endproperty
	a_mask_lo: assert property (p_mask_lo) else $error("lower mask not all valid"); // [R7]

	property p_mask_hi;
		@(posedge ref_clk_i) disable iff (rst_i)
		!rx_write_strobe_n_o |-> rx_byte_mask_o[7:4] == {4{s.wide}};
	endproperty
	a_mask_hi: assert property (p_mask_hi) else $error("upper mask wrong for mode"); // [R8]

	property p_hi_lane;
		@(posedge ref_clk_i) disable iff (rst_i)
		(!rx_write_strobe_n_o && !s.wide) |-> rx_data_o[63:32] == 32'h0;
	endproperty
	a_hi_lane: assert property (p_hi_lane) else $error("upper lane driven in narrow mode"); // [R9]

	property p_lo_order;
		@(posedge ref_clk_i) disable iff (rst_i)
		(s.rx_phase == RX_LOADED && rx_next_command_req_i && !wr_fire && !s.wide) |=>
			rx_data_o[31:0] == ($past(s.big_end) ? bswap($past(s.rx_data[31:0]))
			: $past(s.rx_data[31:0]));
	endproperty
	a_lo_order: assert property (p_lo_order) else $error("lower lane order wrong"); // [R10]

	property p_strobe_pulse;
		@(posedge ref_clk_i) disable iff (rst_i)
		(s.rx_phase == RX_LOADED && rx_next_command_req_i && !wr_fire) |=>
			!rx_write_strobe_n_o ##1 rx_write_strobe_n_o;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe not one cycle"); // [R12]

	property p_dw_flag;
		@(posedge ref_clk_i) disable iff (rst_i)
		(wr_fire && avs_address_i == `LNK_OFS_RX_CMD) |=>
			s.rx_doubleword_flag == $past(avs_writedata_i[`LNK_RX_CMD_DW_BIT]);
	endproperty
	a_dw_flag: assert property (p_dw_flag) else $error("size flag not from bit 2"); // [R13]

	property p_none_pending;
		@(posedge ref_clk_i) disable iff (rst_i)
		(irq_none_pending_o && irq_vector_load_i) |=> !irq_none_pending_o;
	endproperty
	a_none_pending: assert property (p_none_pending) else $error("vector load not taken"); // [R14]

	// Capture and release checks; a new request in the release cycle is ignored, so the release still happens
	property p_beat_store;
		@(posedge ref_clk_i) disable iff (rst_i)
		(!tx_idle_o && !tx_beat_strobe_n_i) |=>
			s.beats[$past(s.wr_ptr)] == $past(tx_data_i);
	endproperty
	a_beat_store: assert property (p_beat_store) else $error("beat not stored"); // [R2]

	property p_idle_return;
		@(posedge ref_clk_i) disable iff (rst_i)
		(wr_fire && avs_address_i == `LNK_OFS_TX_DONE && tx_write_strobe_n_i) |=> tx_idle_o;
	endproperty
	a_idle_return: assert property (p_idle_return) else $error("idle not restored"); // [R3]

	property p_irq_word;
		@(posedge ref_clk_i) disable iff (rst_i)
		(irq_none_pending_o && irq_vector_load_i) |=> s.irq_word == $past(irq_request_word_i);
	endproperty
	a_irq_word: assert property (p_irq_word) else $error("request word not captured"); // [R14]

	property p_irq_refused;
		@(posedge ref_clk_i) disable iff (rst_i)
		(!irq_none_pending_o && irq_vector_load_i) |=> s.irq_word == $past(s.irq_word);
	endproperty
	a_irq_refused: assert property (p_irq_refused) else $error("load taken while pending"); // [R14]

	property p_none_return;
		@(posedge ref_clk_i) disable iff (rst_i)
		(wr_fire && avs_address_i == `LNK_OFS_IRQ_DONE && !irq_vector_load_i) |=>
			irq_none_pending_o;
	endproperty
	a_none_return: assert property (p_none_return) else $error("none-pending not restored"); // [R14]

	property p_mask_idle;
		@(posedge ref_clk_i) disable iff (rst_i)
		rx_write_strobe_n_o |-> rx_byte_mask_o == 8'h00;
	endproperty
	a_mask_idle: assert property (p_mask_idle) else $error("mask valid without strobe"); // [R7]

	// Main scenarios
	c_tx_burst: cover property (@(posedge ref_clk_i) !tx_idle_o && !tx_beat_strobe_n_i);
	c_rx_wide: cover property (@(posedge ref_clk_i) !rx_write_strobe_n_o && s.wide);
	c_irq: cover property (@(posedge ref_clk_i) irq_o && !irq_none_pending_o);
endmodule

// File: lnk_dev_model.sv
// Device-layer model: posted writes, interrupt requests and receive pacing.
// Assumes the node-layer port shares its clock and synchronous reset.
`timescale 1ns/1ns
module lnk_dev_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic tx_idle_i,
	input wire logic irq_none_pending_i,
	input wire logic rx_write_strobe_n_i,
	input wire logic rx_hold_i,
	output logic [39:0] tx_addr_o,
	output logic [63:0] tx_data_o,
	output logic [3:0] tx_write_count_o,
	output logic tx_write_strobe_n_o,
	output logic tx_beat_strobe_n_o,
	output logic [15:0] irq_request_word_o,
	output logic irq_vector_load_o,
	output logic irq_nmi_select_n_o,
	output logic rx_next_command_req_o
);
	logic irq_ff;
	// Quiet values until a task asks for traffic
	initial begin
		tx_addr_o = 40'h0;
		tx_data_o = 64'h0;
		tx_write_count_o = 4'h0;
		tx_write_strobe_n_o = 1'b1;
		tx_beat_strobe_n_o = 1'b1;
		irq_request_word_o = 16'h0;
		irq_vector_load_o = 1'b0;
		irq_nmi_select_n_o = 1'b1;
		rx_next_command_req_o = 1'b0;
		irq_ff = 1'b0;
	end
	// Request flop set on load, dropped by the acknowledge
	always @(posedge ref_clk_i) begin
		if (rst_i || (irq_none_pending_i && !irq_vector_load_o)) begin
			irq_ff <= 1'b0;
		end else if (irq_vector_load_o) begin
			irq_ff <= 1'b1;
		end
	end
	// Busy for a cycle after each command, or while held off
	always @(posedge ref_clk_i) begin
		rx_next_command_req_o <= !rx_hold_i && rx_write_strobe_n_i;
	end
	// Start when idle or after 50 edges of waiting, then one further beat; fields held per strobe
	task automatic send_write(input logic [39:0] a, input logic [3:0] c, input logic [63:0] d0, d1);
		int n;
		n = 0;
		while (tx_idle_i !== 1'b1 && n < 50) begin
			@(posedge ref_clk_i);
			n++;
		end
		tx_addr_o <= a;
		tx_write_count_o <= c;
		tx_data_o <= d0;
		tx_write_strobe_n_o <= 1'b0;
		@(posedge ref_clk_i);
		tx_write_strobe_n_o <= 1'b1;
		tx_data_o <= d1;
		tx_beat_strobe_n_o <= 1'b0;
		@(posedge ref_clk_i);
		tx_beat_strobe_n_o <= 1'b1;
		tx_data_o <= ~d1; // Released data no longer shows the beat
	endtask
	// One-cycle vector load with the request word
	task automatic raise_irq(input logic [15:0] w, input logic nmi_n);
		irq_request_word_o <= w;
		irq_nmi_select_n_o <= nmi_n;
		irq_vector_load_o <= 1'b1;
		@(posedge ref_clk_i);
		irq_vector_load_o <= 1'b0;
		irq_request_word_o <= ~w;
	endtask
endmodule

// File: tb_link_device_layer_port.sv
// Bench for the node-layer port: Avalon master, rx scoreboard, device model.
// Assumes lnk_defs.svh, lnk_pkg and the model are compiled first.
`timescale 1ns/1ns
`include "lnk_defs.svh"
module tb_link_device_layer_port;
	import lnk_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, irq_o, tx_idle_o, irq_none_pending_o;
	logic [39:0] tx_addr_i;
	logic [63:0] tx_data_i;
	logic [3:0] tx_write_count_i;
	logic tx_write_strobe_n_i, tx_beat_strobe_n_i, irq_vector_load_i, irq_nmi_select_n_i;
	logic [15:0] irq_request_word_i;
	logic rx_next_command_req_i, rx_write_strobe_n_o, rx_doubleword_flag_o;
	logic [39:2] rx_addr_o;
	logic [63:0] rx_data_o;
	logic [7:0] rx_byte_mask_o;
	logic rx_hold = 1'b0;
	logic [31:0] rd_q[$];
	logic [110:0] rx_q[$];
	int miscompares = 0;
	int n_checks = 0;
	logic [39:0] a;
	logic [63:0] d0, d1;
	logic [31:0] lo, hi;
	logic [15:0] w;
	logic [3:0] c;
	// 125 MHz core clock
	always #4 ref_clk_i = ~ref_clk_i;
	lnk_node_port #(.BEATS(16)) u_dut (
		.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .tx_addr_i,
		.tx_data_i, .tx_write_count_i, .tx_write_strobe_n_i, .tx_beat_strobe_n_i,
		.tx_idle_o, .irq_request_word_i, .irq_vector_load_i, .irq_nmi_select_n_i,
		.irq_none_pending_o, .rx_addr_o, .rx_data_o, .rx_byte_mask_o,
		.rx_next_command_req_i, .rx_write_strobe_n_o, .rx_doubleword_flag_o);
	lnk_dev_model u_dev (
		.ref_clk_i, .rst_i, .tx_idle_i(tx_idle_o), .irq_none_pending_i(irq_none_pending_o),
		.rx_write_strobe_n_i(rx_write_strobe_n_o), .rx_hold_i(rx_hold),
		.tx_addr_o(tx_addr_i), .tx_data_o(tx_data_i), .tx_write_count_o(tx_write_count_i),
		.tx_write_strobe_n_o(tx_write_strobe_n_i), .tx_beat_strobe_n_o(tx_beat_strobe_n_i),
		.irq_request_word_o(irq_request_word_i), .irq_vector_load_o(irq_vector_load_i),
		.irq_nmi_select_n_o(irq_nmi_select_n_i), .rx_next_command_req_o(rx_next_command_req_i));
	task automatic end_of_test();
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic hang();
		miscompares++;
		end_of_test();
	endtask
	task automatic cmp_pin(input string nm, input logic e, g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic cmp_bus(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_cmd(input string nm, input logic [110:0] e, g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Held request until waitrequest is seen low, then one idle edge
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= ad;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 40);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge ref_clk_i);
		if (n >= 40) hang();
	endtask
	task automatic bw(input logic [7:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d);
	endtask
	task automatic br(input logic [7:0] ad, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, ad, 32'h0);
	endtask
	// Expected receive lanes: m[0] wide, m[1] big endian
	function automatic logic [63:0] lanes(input logic [31:0] l, h, input logic [1:0] m);
		logic [63:0] v;
		logic [31:0] r;
		r = {<<8{l}};
		v = m[0] ? {h, l} : {32'h0, l};
		if (m[1] && m[0]) v = {<<8{v}};
		if (m[1] && !m[0]) v = {32'h0, r};
		return v;
	endfunction
	// Scoreboard: read data at the accepting edge, rx command at its strobe
	always @(posedge ref_clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0 && rd_q.size() > 0) begin
			cmp_bus("readdata", rd_q.pop_front(), avs_readdata_o);
		end
		if (rx_write_strobe_n_o === 1'b0) begin
			cmp_pin("rx strobe wanted", 1'b1, rx_q.size() != 0);
			if (rx_q.size() != 0) begin
				cmp_cmd("rx command", rx_q.pop_front(), {rx_addr_o, rx_data_o, rx_byte_mask_o,
					rx_doubleword_flag_o});
			end
		end
	end
	initial begin
		void'($urandom(32'h88ba));
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		// Reset levels, control reset value, unmapped read
		cmp_pin("tx_idle", 1'b1, tx_idle_o);
		cmp_pin("none_pending", 1'b1, irq_none_pending_o);
		cmp_pin("rx strobe", 1'b1, rx_write_strobe_n_o);
		cmp_pin("irq", 1'b0, irq_o);
		br(`LNK_OFS_CTRL, 32'h0);
		br(`LNK_OFS_STATUS, 32'h0);
		br(8'hfc, 32'h0);
		// Posted write with one further beat, seen through the registers
		a = {8'($urandom), $urandom};
		d0 = {$urandom, $urandom};
		d1 = {$urandom, $urandom};
		c = 4'($urandom);
		bw(`LNK_OFS_IRQ_MASK, 32'h7);
		u_dev.send_write(a, c, d0, d1);
		cmp_pin("tx_idle busy", 1'b0, tx_idle_o);
		br(`LNK_OFS_TX_ADDR_LO, a[31:0]);
		br(`LNK_OFS_TX_ADDR_HI, {20'h0, c, a[39:32]});
		br(`LNK_OFS_TX_DATA_LO, d0[31:0]);
		br(`LNK_OFS_TX_DATA_HI, d0[63:32]);
		br(`LNK_OFS_TX_DATA_LO, d1[31:0]);
		br(`LNK_OFS_TX_DATA_HI, d1[63:32]);
		cmp_pin("irq", 1'b1, irq_o);
		br(`LNK_OFS_IRQ_STAT, 32'h1);
		cmp_pin("irq cleared", 1'b0, irq_o);
		bw(`LNK_OFS_TX_DONE, 32'h0);
		cmp_pin("tx_idle", 1'b1, tx_idle_o);
		// Unprogrammed vector, programmed fixed type, select low; reload refused
		for (int i = 0; i < 3; i++) begin
			w = 16'($urandom);
			if (i == 1) bw(`LNK_OFS_VECTOR, {16'h0, w});
			u_dev.raise_irq(w, i != 2);
			@(posedge ref_clk_i);
			cmp_pin("none_pending", 1'b0, irq_none_pending_o);
			u_dev.raise_irq(~w, 1'b0);
			br(`LNK_OFS_IRQ_WORD, {15'h0, i != 1, w});
			br(`LNK_OFS_IRQ_STAT, 32'h2);
			bw(`LNK_OFS_IRQ_DONE, 32'h0);
			cmp_pin("none_pending", 1'b1, irq_none_pending_o);
			@(posedge ref_clk_i);
			cmp_pin("request flop", 1'b0, u_dev.irq_ff);
		end
		// Every width and endian mode, both sizes, rx event masked
		bw(`LNK_OFS_IRQ_MASK, 32'h3);
		for (int i = 0; i < 8; i++) begin
			a = {8'($urandom), $urandom};
			lo = $urandom;
			hi = $urandom;
			bw(`LNK_OFS_CTRL, {30'h0, i[1:0]});
			bw(`LNK_OFS_RX_ADDR_LO, a[31:0]);
			bw(`LNK_OFS_RX_ADDR_HI, {24'h0, a[39:32]});
			bw(`LNK_OFS_RX_DATA_LO, lo);
			bw(`LNK_OFS_RX_DATA_HI, hi);
			rx_hold <= (i == 3);
			rx_q.push_back({a[39:2], lanes(lo, hi, i[1:0]), i[0] ? 8'hff : 8'h0f, i[2]});
			bw(`LNK_OFS_RX_CMD, {29'h0, i[2], 2'h0});
			if (i == 3) begin
				repeat (6) @(posedge ref_clk_i);
				cmp_pin("rx held", 1'b1, rx_q.size() != 0);
				rx_hold <= 1'b0;
			end
			for (int n = 0; rx_q.size() != 0; n++) begin
				if (n > 30) hang();
				@(posedge ref_clk_i);
			end
			cmp_pin("irq masked", 1'b0, irq_o);
			br(`LNK_OFS_IRQ_STAT, 32'h4);
		end
		cmp_pin("drained", 1'b1, rd_q.size() == 0);
		end_of_test();
	end
endmodule
